// ---- design/sample_ready_router.v ----
`timescale 1ns/1ps
`include "accel_readout_defines.vh"
module sample_ready_router #(
  parameter [21:0] SYS_SLOW_CYC = `SYS_SLOW_CYCLES,
  parameter [21:0] SYS_FAST_CYC = `SYS_FAST_CYCLES,
  parameter [21:0] EXT_SLOW_CYC = `EXT_SLOW_CYCLES,
  parameter [21:0] EXT_FAST_CYC = `EXT_FAST_CYCLES
) (
  input wire clk_sys,
  input wire srst,
  input wire ext_clk,
  input wire [7:0] accel_x,
  input wire [7:0] accel_y,
  input wire [7:0] accel_z,
  input wire motion1_cond,
  input wire motion2_cond,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  output reg first_output_pin,
  output reg second_output_pin
);

  // ****************************************
  // Pin routing function
  // ****************************************
  // Picks the signal a pin carries from its selector
  function route_pin;
    input [2:0] sel;
    input ready;
    input src1;
    input src2;
    begin
      case (sel)
        `PIN_SEL_READY: route_pin = ready;
        `PIN_SEL_SRC1: route_pin = src1;
        `PIN_SEL_SRC2: route_pin = src2;
        `PIN_SEL_OR: route_pin = src1 | src2;
        default: route_pin = 1'b0;
      endcase
    end
  endfunction

  // True when a strobe targets the given register address
  function addr_hit;
    input strobe;
    input [7:0] addr;
    input [7:0] target;
    begin
      addr_hit = strobe && (addr == target);
    end
  endfunction

  // ****************************************
  // Registers and state
  // ****************************************
  reg [7:0] control_one; // Rate, time base, axis enables
  reg [7:0] pin_function_control; // Pin selectors and latch bit
  reg [7:0] data_x; // Readable X sample
  reg [7:0] data_y; // Readable Y sample
  reg [7:0] data_z; // Readable Z sample
  reg sample_ready; // New set waiting for the host
  reg overrun; // Sticky: a set was lost
  reg [2:0] read_mask; // Axes read since last load
  reg src1; // Interrupt source one state
  reg src2; // Interrupt source two state
  reg [21:0] period_cnt; // Output period counter
  reg ext_meta; // External clock, first stage
  reg ext_sync; // External clock, second stage
  reg ext_prev; // Delayed copy for edge finding

  // ****************************************
  // Decoded controls
  // ****************************************
  wire rate_select_bit; // 1 selects the fast rate
  wire use_ext; // Time base from external clock
  wire [2:0] axis_en; // Enabled axis channels
  wire latch_request_bit; // Hold sources until read
  wire ext_rise; // Rising edge of external clock
  wire step; // One time-base unit elapsed
  wire [21:0] period_len; // Units per output period
  wire sample_tick; // A new sample set is produced
  wire wr_ctrl; // Write to control_one
  wire wr_pin; // Write to pin_function_control
  wire rd_status; // Read of sample_status
  wire rd_src1; // Read of source one register
  wire rd_src2; // Read of source two register
  wire [2:0] rd_axis; // Axis registers read this cycle
  wire [2:0] next_read_mask; // Mask including this read
  wire all_read; // Every enabled axis is read
  wire buf_in_ready; // Buffer can take a set
  wire buf_out_valid; // Buffer holds a set
  wire [23:0] buf_out_data; // Oldest buffered set
  wire load_set; // Move a set into the data regs
  wire [7:0] sample_status; // Status register image

  assign rate_select_bit = control_one[`RATE_SELECT_BIT];
  assign use_ext = control_one[`EXT_TIMEBASE_BIT];
  assign axis_en = control_one[`AXIS_EN_MSB:`AXIS_EN_LSB];
  assign latch_request_bit = pin_function_control[`LATCH_REQUEST_BIT];

  // Register strobes decoded by address
  assign wr_ctrl = addr_hit(reg_wr, reg_addr, `ADDR_CONTROL_ONE);
  assign wr_pin = addr_hit(reg_wr, reg_addr, `ADDR_PIN_FUNC);
  assign rd_status = addr_hit(reg_rd, reg_addr, `ADDR_STATUS);
  assign rd_src1 = addr_hit(reg_rd, reg_addr, `ADDR_SRC1);
  assign rd_src2 = addr_hit(reg_rd, reg_addr, `ADDR_SRC2);
  assign rd_axis[0] = addr_hit(reg_rd, reg_addr, `ADDR_AXIS_X);
  assign rd_axis[1] = addr_hit(reg_rd, reg_addr, `ADDR_AXIS_Y);
  assign rd_axis[2] = addr_hit(reg_rd, reg_addr, `ADDR_AXIS_Z);

  // ****************************************
  // External clock sampling
  // ****************************************
  // Two flops bring the pin in; a third finds edges
  always @(posedge clk_sys) begin
    if (srst) begin
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
      ext_prev <= 1'b0;
    end else begin
      ext_meta <= ext_clk;
      ext_sync <= ext_meta;
      ext_prev <= ext_sync;
    end
  end

  // Sync stages reset low, so a pin held high at release gives one early step
  assign ext_rise = ext_sync && !ext_prev;

  // ****************************************
  // Output rate time base
  // ****************************************
  // Period length follows the rate bit and time base
  assign period_len = use_ext ?
    (rate_select_bit ? EXT_FAST_CYC : EXT_SLOW_CYC) :
    (rate_select_bit ? SYS_FAST_CYC : SYS_SLOW_CYC);
  // The internal base steps on every clock
  assign step = use_ext ? ext_rise : 1'b1;
  // Compare with >= so a shorter period after a rate change ends at its next step
  assign sample_tick = step && (period_cnt >= period_len - 22'h1);

  // Counts time-base units through one output period
  always @(posedge clk_sys) begin
    if (srst) begin
      period_cnt <= 22'h0;
    end else if (sample_tick) begin
      period_cnt <= 22'h0;
    end else if (step) begin
      period_cnt <= period_cnt + 22'h1;
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  // Software writes; reset puts the slow rate in place
  always @(posedge clk_sys) begin
    if (srst) begin
      control_one <= `RESET_CONTROL_ONE;
      pin_function_control <= `RESET_PIN_FUNC;
    end else begin
      if (wr_ctrl)
        control_one <= reg_wdata;
      if (wr_pin)
        pin_function_control <= reg_wdata;
    end
  end

  // ****************************************
  // Sample buffer
  // ****************************************
  // Sets wait here while the host is still reading
  sample_pair_buffer #(
    .WIDTH(24)
  ) u_sample_buffer (
    .clk_sys(clk_sys),
    .srst(srst),
    .in_valid(sample_tick),
    .in_ready(buf_in_ready),
    .in_data({accel_z, accel_y, accel_x}),
    .out_valid(buf_out_valid),
    .out_ready(load_set),
    .out_data(buf_out_data)
  );

  // A set moves to the readable registers only after the last one is done
  // Buffer full means two sets wait behind the displayed one
  assign load_set = buf_out_valid && !sample_ready;

  // ****************************************
  // Sample ready and read tracking
  // ****************************************
  // Reads of disabled axes land in the mask but never matter
  assign next_read_mask = read_mask | rd_axis;
  assign all_read = ((next_read_mask & axis_en) == axis_en);

  // Ready rises on load, falls when every enabled axis is read
  always @(posedge clk_sys) begin
    if (srst) begin
      sample_ready <= 1'b0;
      read_mask <= 3'h0;
      data_x <= 8'h00;
      data_y <= 8'h00;
      data_z <= 8'h00;
    end else if (load_set) begin
      sample_ready <= 1'b1;
      read_mask <= 3'h0;
      data_x <= buf_out_data[7:0];
      data_y <= buf_out_data[15:8];
      data_z <= buf_out_data[23:16];
    end else if (sample_ready) begin
      read_mask <= next_read_mask;
      if (all_read)
        sample_ready <= 1'b0;
    end
  end

  // ****************************************
  // Overrun flag
  // ****************************************
  // A set arriving with the buffer full is lost; new loss beats the clear
  // A status read clears it after the read data has captured it
  always @(posedge clk_sys) begin
    if (srst) begin
      overrun <= 1'b0;
    end else begin
      overrun <= (sample_tick && !buf_in_ready) || (overrun && !rd_status);
    end
  end

  // ****************************************
  // Interrupt sources
  // ****************************************
  // Follow the condition, or hold it until the source register is read
  always @(posedge clk_sys) begin
    if (srst) begin
      src1 <= 1'b0;
      src2 <= 1'b0;
    end else begin
      src1 <= motion1_cond || (src1 && latch_request_bit && !rd_src1);
      src2 <= motion2_cond || (src2 && latch_request_bit && !rd_src2);
    end
  end

  // ****************************************
  // Output pins
  // ****************************************
  // Each pin takes the signal named by its selector field
  always @(posedge clk_sys) begin
    if (srst) begin
      first_output_pin <= 1'b0;
      second_output_pin <= 1'b0;
    end else begin
      first_output_pin <= route_pin(
        pin_function_control[`PIN1_SEL_MSB:`PIN1_SEL_LSB],
        sample_ready, src1, src2);
      second_output_pin <= route_pin(
        pin_function_control[`PIN2_SEL_MSB:`PIN2_SEL_LSB],
        sample_ready, src1, src2);
    end
  end

  // ****************************************
  // Register read port
  // ****************************************
  assign sample_status = {overrun, 3'h0, sample_ready, 3'h0};

  // Read data appears one cycle after the read strobe
  always @(posedge clk_sys) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `ADDR_CONTROL_ONE: reg_rdata <= control_one;
        `ADDR_PIN_FUNC: reg_rdata <= pin_function_control;
        `ADDR_STATUS: reg_rdata <= sample_status;
        `ADDR_AXIS_X: reg_rdata <= data_x;
        `ADDR_AXIS_Y: reg_rdata <= data_y;
        `ADDR_AXIS_Z: reg_rdata <= data_z;
        `ADDR_SRC1: reg_rdata <= {7'h00, src1};
        `ADDR_SRC2: reg_rdata <= {7'h00, src2};
        default: reg_rdata <= 8'h00; // Unmapped reads as zero
      endcase
    end
  end

endmodule

// ---- design/accel_readout_defines.vh ----
`ifndef ACCEL_READOUT_DEFINES_VH
`define ACCEL_READOUT_DEFINES_VH

// ****************************************
// Register byte addresses
// ****************************************
`define ADDR_CONTROL_ONE 8'h20
`define ADDR_PIN_FUNC 8'h30
`define ADDR_STATUS 8'h31
`define ADDR_AXIS_X 8'h32
`define ADDR_AXIS_Y 8'h33
`define ADDR_AXIS_Z 8'h34
`define ADDR_SRC1 8'h35
`define ADDR_SRC2 8'h36

// ****************************************
// Field positions
// ****************************************
`define RATE_SELECT_BIT 7
`define EXT_TIMEBASE_BIT 6
`define AXIS_EN_MSB 2
`define AXIS_EN_LSB 0
`define PIN1_SEL_MSB 2
`define PIN1_SEL_LSB 0
`define PIN2_SEL_MSB 5
`define PIN2_SEL_LSB 3
`define LATCH_REQUEST_BIT 6
`define STAT_READY_BIT 3
`define STAT_OVERRUN_BIT 7

// ****************************************
// Pin selector codes
// ****************************************
`define PIN_SEL_SRC1 3'h1
`define PIN_SEL_SRC2 3'h2
`define PIN_SEL_OR 3'h3
`define PIN_SEL_READY 3'h4

// ****************************************
// Reset values
// ****************************************
`define RESET_CONTROL_ONE 8'h07
`define RESET_PIN_FUNC 8'h00

// ****************************************
// Timing
// ****************************************
`define SYS_CLK_NS 4
`define EXT_CLK_NS 48
`define SLOW_PERIOD_MS 10
`define FAST_PERIOD_US 2500
`define NS_PER_MS 1000000
`define NS_PER_US 1000
`define PERIOD_CNT_W 22
// Default periods in time-base units: 10 ms and 2.5 ms over 4 ns and 48 ns
`define SYS_SLOW_CYCLES 22'h2625A0
`define SYS_FAST_CYCLES 22'h98968
`define EXT_SLOW_CYCLES 22'h32DCD
`define EXT_FAST_CYCLES 22'hCB73

`endif

// ---- design/sample_pair_buffer.v ----
`timescale 1ns/1ps
// Two-entry buffer holding complete sample sets
module sample_pair_buffer #(
  parameter WIDTH = 24
) (
  input wire clk_sys,
  input wire srst,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] slot0; // Head entry
  reg [WIDTH-1:0] slot1; // Second entry
  reg [1:0] fill; // Entries held, 0 to 2

  wire push; // Entry accepted
  wire pop; // Entry drained

  assign in_ready = (fill != 2'h2);
  assign out_valid = (fill != 2'h0);
  assign out_data = slot0;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // ****************************************
  // Storage and fill count
  // ****************************************
  always @(posedge clk_sys) begin
    if (srst) begin
      fill <= 2'h0;
      slot0 <= {WIDTH{1'b0}};
      slot1 <= {WIDTH{1'b0}};
    end else begin
      case ({push, pop})
        2'b10: begin
          // Fill the first free entry
          if (fill == 2'h0)
            slot0 <= in_data;
          else
            slot1 <= in_data;
          fill <= fill + 2'h1;
        end
        2'b01: begin
          // Shift the second entry forward
          slot0 <= slot1;
          fill <= fill - 2'h1;
        end
        2'b11: begin
          // Drain and refill in one cycle
          if (fill == 2'h1)
            slot0 <= in_data;
          else begin
            slot0 <= slot1;
            slot1 <= in_data;
          end
        end
        default: begin
          // Hold
          fill <= fill;
        end
      endcase
    end
  end

endmodule

// ---- verif/accel_readout_properties.sv ----
`timescale 1ns/1ps
// ****
// Pin routing and register readback checks
// ****
module accel_readout_properties (
  input wire clk_sys,
  input wire srst,
  input wire motion1_cond,
  input wire motion2_cond,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire first_output_pin,
  input wire second_output_pin
);
  reg [7:0] ctrl; // Shadow of control_one
  reg [7:0] pf; // Shadow of pin_function_control
  reg [1:0] age; // Cycles since selector write
  wire rd_axis = reg_rd && reg_addr >= 8'h32 && reg_addr <= 8'h34;
  wire rd_src1 = reg_rd && reg_addr == 8'h35;
  wire steady = age == 2'h3 && !pf[6];
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  // Track register writes
  always @(posedge clk_sys) begin
    if (srst) begin
      ctrl <= 8'h07;
      pf <= 8'h00;
      age <= 2'h0;
    end else begin
      if (reg_wr && reg_addr == 8'h20) begin
        ctrl <= reg_wdata;
      end
      if (reg_wr && reg_addr == 8'h30) begin
        pf <= reg_wdata;
        age <= 2'h0;
      end else if (age != 2'h3) begin
        age <= age + 2'h1;
      end
    end
  end
  a_src1_route: assert property (
    steady && pf[2:0] == 3'h1 |-> first_output_pin == $past(motion1_cond, 2))
    else $error("pin one not following source one");
  a_or_route: assert property (
    steady && pf[2:0] == 3'h3 |->
    first_output_pin == ($past(motion1_cond, 2) || $past(motion2_cond, 2)))
    else $error("pin one not the OR of sources");
  a_pin2_src2: assert property (
    steady && pf[5:3] == 3'h2 |-> second_output_pin == $past(motion2_cond, 2))
    else $error("pin two not following source two");
  a_unused_low: assert property (
    age == 2'h3 && (pf[2:0] == 3'h0 || pf[2:0] > 3'h4) |-> !first_output_pin)
    else $error("unused code drives pin one");
  a_ready_clear: assert property (
    age == 2'h3 && pf[2:0] == 3'h4 && ctrl[2:0] != 3'h0 && $fell(first_output_pin)
    |-> $past(rd_axis, 2))
    else $error("ready fell without axis read");
  a_status_mirror: assert property (
    age == 2'h3 && pf[2:0] == 3'h4 && reg_rd && reg_addr == 8'h31
    |=> reg_rdata[3] == first_output_pin)
    else $error("status ready bit differs from pin");
  a_ctrl_readback: assert property (
    reg_rd && reg_addr == 8'h20 |=> reg_rdata == ctrl)
    else $error("control_one readback wrong");
  a_latch_hold: assert property (
    age == 2'h3 && pf[6] && pf[2:0] == 3'h1 && $fell(first_output_pin)
    |-> $past(rd_src1, 1) || $past(rd_src1, 2))
    else $error("latched source dropped without read");
endmodule

// ---- verif/host_model.sv ----
`timescale 1ns/1ps
// ****
// Host reading samples
// ****
module host_model (
  input wire clk_sys,
  input wire ready_pin,
  input wire auto_en,
  input wire [7:0] reg_rdata,
  output reg [7:0] reg_addr = 8'h00,
  output reg [7:0] reg_wdata = 8'h00,
  output reg reg_wr = 1'b0,
  output reg reg_rd = 1'b0
);
  reg ready_q = 1'b0; // Pin level at last edge
  reg [7:0] last = 8'h00; // Last value read
  // Write strobe, lines scrambled once released
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
    end
  endtask
  // Read strobe, data taken after answer edge
  task rd(input [7:0] a);
    begin
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      #1 last = reg_rdata;
    end
  endtask
  // Reads the whole set promptly on each ready rise
  initial forever begin
    @(posedge clk_sys);
    if (auto_en && ready_pin && !ready_q) begin
      rd(8'h32);
      rd(8'h33);
      rd(8'h34);
    end
    // A pin seen while idle counts as low, so enabling on a high pin reads
    ready_q = ready_pin && auto_en;
  end
endmodule

// ---- verif/test_sample_ready_and_irq_pin_routing.sv ----
`timescale 1ns/1ps
`define CHK(n, e, a) begin \
  samples_checked = samples_checked + 1; \
  if ((a) !== (e)) begin \
    num_errors = num_errors + 1; \
    $display("ERROR %s expected %0h seen %0h", n, e, a); \
  end \
end
// ****
// Readout bench
// ****
module test_sample_ready_and_irq_pin_routing;
  reg clk_sys = 1'b0; // System clock
  reg srst = 1'b1; // Synchronous reset
  reg ext_clk = 1'b0; // External time base
  reg ext_run = 1'b1; // Time base running
  reg m1 = 1'b0; // Source one condition
  reg m2 = 1'b0; // Source two condition
  reg auto_en = 1'b0; // Host reads on its own
  reg [7:0] ax = 8'hA1; // X sample at the sensing input
  reg [7:0] ay = 8'hB2; // Y sample at the sensing input
  reg [7:0] az = 8'h3C; // Z sample at the sensing input
  wire [7:0] reg_addr, reg_wdata, reg_rdata;
  wire reg_wr, reg_rd, pin1, pin2;
  integer num_errors = 0;
  integer samples_checked = 0;
  integer cyc = 0;
  integer i, n, c, e;
  initial forever #2 clk_sys = ~clk_sys;
  // Free time base, phase unrelated to clk_sys
  initial begin
    #1.3;
    forever #24 ext_clk = ext_run ? ~ext_clk : ext_clk;
  end
  always @(posedge clk_sys) cyc <= cyc + 1;
  sample_ready_router #(.SYS_SLOW_CYC(22'd40), .SYS_FAST_CYC(22'd10),
    .EXT_SLOW_CYC(22'd8), .EXT_FAST_CYC(22'd2)) dut (.clk_sys(clk_sys),
    .srst(srst), .ext_clk(ext_clk), .accel_x(ax), .accel_y(ay),
    .accel_z(az), .motion1_cond(m1), .motion2_cond(m2), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .first_output_pin(pin1), .second_output_pin(pin2));
  host_model host (.clk_sys(clk_sys), .ready_pin(pin1), .auto_en(auto_en),
    .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd));
  // Verdict and end of run
  task summarize;
    begin
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  // Masked register read and compare
  task rdc(input [7:0] a, input [7:0] m, input [7:0] x);
    begin
      host.rd(a);
      `CHK("register", x, host.last & m)
    end
  endtask
  // Bounded wait for pin one level
  task wpin(input v);
    begin
      n = 0;
      while (pin1 !== v && n < 300) begin
        @(posedge clk_sys);
        n = n + 1;
      end
      if (pin1 !== v) begin
        `CHK("wait", 1'b1, 1'b0)
        summarize;
      end
    end
  endtask
  // Cycles between two ready rises
  task gap;
    begin
      wpin(1'b0);
      wpin(1'b1);
      c = cyc;
      wpin(1'b0);
      wpin(1'b1);
      c = cyc - c;
    end
  endtask
  // Expected pin for a selector code
  function route(input [2:0] s);
    begin
      route = (s == 3'h1 && m1) || (s == 3'h2 && m2) || (s == 3'h3 && (m1 || m2));
    end
  endfunction
  // Quiet the host, then pulse reset
  task rst;
    begin
      auto_en <= 1'b0;
      repeat (8) @(posedge clk_sys);
      srst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      srst <= 1'b0;
    end
  endtask
  // ****
  // Main sequence
  // ****
  initial begin
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    rdc(8'h20, 8'hFF, 8'h07);
    rdc(8'h30, 8'hFF, 8'h00);
    rdc(8'h3F, 8'hFF, 8'h00);
    host.wr(8'h30, 8'h04);
    for (i = 0; i < 4; i = i + 1) begin
      auto_en <= 1'b0;
      repeat (8) @(posedge clk_sys);
      az <= 8'h3C + i[7:0];
      host.wr(8'h20, {i[0], i[1], 6'h07});
      auto_en <= 1'b1;
      e = i[1] ? (i[0] ? 24 : 96) : (i[0] ? 10 : 40);
      gap;
      gap;
      `CHK("period", 1'b1, (c - e) * (c - e) <= i[1])
      repeat (8) @(posedge clk_sys);
      `CHK("axis z", 8'h3C + i[7:0], host.last)
    end
    rst;
    ax <= 8'h5A;
    az <= 8'h3C;
    rdc(8'h20, 8'hFF, 8'h07);
    host.wr(8'h30, 8'h04);
    host.wr(8'h20, 8'h01);
    wpin(1'b1);
    rdc(8'h31, 8'h08, 8'h08);
    rdc(8'h33, 8'hFF, 8'hB2);
    `CHK("pin held", 1'b1, pin1)
    rdc(8'h32, 8'hFF, 8'h5A);
    repeat (3) @(posedge clk_sys);
    `CHK("pin cleared", 1'b0, pin1)
    rdc(8'h31, 8'h08, 8'h00);
    host.wr(8'h20, 8'h47);
    repeat (500) @(posedge clk_sys);
    ext_run = 1'b0;
    repeat (40) @(posedge clk_sys);
    rdc(8'h31, 8'h88, 8'h88);
    rdc(8'h31, 8'h80, 8'h00);
    for (i = 0; i < 3; i = i + 1) begin
      host.rd(8'h32);
      host.rd(8'h33);
      rdc(8'h34, 8'hFF, 8'h3C);
      repeat (5) @(posedge clk_sys);
      `CHK("buffered set", i < 2, pin1)
    end
    ext_run = 1'b1;
    for (i = 0; i < 16; i = i + 1) begin
      m1 <= i[3];
      m2 <= ~i[3];
      host.wr(8'h30, {2'b00, i[2:0] + 3'h1, i[2:0]});
      repeat (4) @(posedge clk_sys);
      if (i[2:0] != 3'h4) `CHK("pin one", route(i[2:0]), pin1)
      if (i[2:0] != 3'h3) `CHK("pin two", route(i[2:0] + 3'h1), pin2)
    end
    host.wr(8'h30, 8'h51);
    @(posedge clk_sys);
    m1 <= 1'b0;
    m2 <= 1'b1;
    @(posedge clk_sys);
    m2 <= 1'b0;
    repeat (6) @(posedge clk_sys);
    `CHK("latched pin", 1'b1, pin1)
    `CHK("latched pin two", 1'b1, pin2)
    rdc(8'h35, 8'h01, 8'h01);
    repeat (4) @(posedge clk_sys);
    `CHK("released pin", 1'b0, pin1)
    `CHK("pin two kept", 1'b1, pin2)
    rdc(8'h36, 8'h01, 8'h01);
    repeat (4) @(posedge clk_sys);
    `CHK("released pin two", 1'b0, pin2)
    rdc(8'h35, 8'h01, 8'h00);
    summarize;
  end
endmodule
bind sample_ready_router accel_readout_properties chk (.clk_sys, .srst, .motion1_cond,
  .motion2_cond, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .first_output_pin, .second_output_pin);
